//--- tb/emi_ext_data_mem_chk.sv
// checker: pin timing relations of the external memory interface.
// assumes a bind to emi_ext_data_mem; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
// ****************
// pin checker
// ****************
module emi_chk (
	// clock and reset
	input wire logic       clk,
	input wire logic       rstn,
	// move status
	input wire logic       mv_busy_q,
	input wire logic       mv_done_q,
	// bus pins
	input wire logic       ext_addr_hi_oe_q,
	input wire logic [7:0] ext_addr_lo_q,
	input wire logic       ext_data_oe_q,
	input wire logic       ext_rd_n_q,
	input wire logic       ext_wr_n_q,
	input wire logic       ext_ale_q
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// strobes end within sixteen cycles
	sequence s_rd_end;
		##[0:15] ext_rd_n_q;
	endsequence
	sequence s_wr_end;
		##[0:15] ext_wr_n_q;
	endsequence
	// latch high phase ends within four cycles
	sequence s_ale_end;
		##[0:3] !ext_ale_q;
	endsequence
	a_rd_width: assert property ($fell(ext_rd_n_q) |=> s_rd_end)
		else $error("read strobe too long");
	a_wr_width: assert property ($fell(ext_wr_n_q) |=> s_wr_end)
		else $error("write strobe too long");
	a_ale_high: assert property ($rose(ext_ale_q) |=> s_ale_end)
		else $error("latch pulse too long");
	a_ale_bus: assert property (ext_ale_q |-> ext_data_oe_q
		&& ext_rd_n_q && ext_wr_n_q)
		else $error("latch phase without address on bus");
	a_rd_bus: assert property (!ext_rd_n_q |-> !ext_ale_q
		&& !ext_data_oe_q && ext_wr_n_q)
		else $error("bus driven during read strobe");
	a_wr_data: assert property (!ext_wr_n_q |-> ext_data_oe_q)
		else $error("write strobe without data");
	a_addr_hold: assert property (!ext_rd_n_q && !$fell(ext_rd_n_q)
		|-> $stable(ext_addr_lo_q))
		else $error("address moved during strobe");
	a_move_bound: assert property ($rose(mv_busy_q)
		|-> ##[2:33] mv_done_q)
		else $error("move did not end in time");
	a_done_once: assert property (mv_done_q |=> !mv_done_q
		&& !mv_busy_q)
		else $error("done not a single pulse");
	a_idle_quiet: assert property (!mv_busy_q |-> ext_rd_n_q
		&& ext_wr_n_q && !ext_data_oe_q && !ext_addr_hi_oe_q && !ext_ale_q)
		else $error("pins active while idle");
endmodule // emi_chk
`default_nettype wire

//--- tb/emi_xmem.sv
// partner model: external parallel memory on the interface bus pins.
// assumes active-low strobes and an address latch driven by ale.
`timescale 1ns/1ns
`default_nettype none
// ****************
// external memory
// ****************
module emi_xmem (
	// clock
	input  wire logic       clk,
	// address pins
	input  wire logic [7:0] ext_addr_hi_q,
	input  wire logic       ext_addr_hi_oe_q,
	input  wire logic [7:0] ext_addr_lo_q,
	input  wire logic       ext_addr_lo_oe_q,
	// data bus and strobes
	output wire logic [7:0] ext_data_i,
	input  wire logic [7:0] ext_data_o_q,
	input  wire logic       ext_rd_n_q,
	input  wire logic       ext_wr_n_q,
	input  wire logic       ext_ale_q
);
	logic [7:0]  mem [0:65535];
	logic [7:0]  lat_q;
	logic [7:0]  lst_q = 8'h00;
	logic        idle_q = 1'b1;
	logic [15:0] a;
	int          n_strb = 0;
	logic [15:0] l_addr;
	logic        l_hioe;
	// undriven high lines read as zero from the port latches
	assign a = {ext_addr_hi_oe_q ? ext_addr_hi_q : 8'h00,
		ext_addr_lo_oe_q ? ext_addr_lo_q : lat_q};
	// released bus shows the inverse of the last value
	assign ext_data_i = ext_rd_n_q ? ~lst_q : mem[a];
	// latch, write storage and strobe log
	always @(posedge clk) begin
		if (ext_ale_q)
			lat_q <= ext_data_o_q;
		if (!ext_wr_n_q)
			mem[a] <= ext_data_o_q;
		if (!ext_rd_n_q)
			lst_q <= mem[a];
		idle_q <= ext_rd_n_q & ext_wr_n_q;
		if (idle_q && !(ext_rd_n_q & ext_wr_n_q)) begin
			n_strb <= n_strb + 1;
			l_addr <= a;
			l_hioe <= ext_addr_hi_oe_q;
		end
	end
endmodule // emi_xmem
`default_nettype wire

//--- tb/testbench.sv
// testbench: register and move sequences with expected results.
// assumes the partner memory model and the pin checker.
`timescale 1ns/1ns
`default_nettype none
`include "emi_defines.vh"
// ****************
// bench top
// ****************
module testbench;
	logic clk, rstn, rd, wr, req, mw, mwd, msel, wq, bz, hoe, loe, doe;
	logic rdn, wrn, ale, dn;
	logic [9:0]  adr;
	logic [31:0] wdat, rdat;
	logic [3:0]  be;
	logic [15:0] dp;
	logic [7:0]  p0, p1, mwv, mrd, ah, al, di, dout, r;
	logic [7:0]  tv [3] = '{8'hff, 8'h9e, 8'h00};
	int          ne [3] = '{26, 16, 5};
	int n_errors = 0;
	int samples_checked = 0;
	int n, s, i;
	// device and far-side memory
	emi_ext_data_mem DUT (.clk(clk), .rstn(rstn), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
		.avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq),
		.mv_req(req), .mv_write(mw), .mv_wide(mwd), .mv_ptr_sel(msel),
		.data_pointer(dp), .indirect_pointer_zero(p0),
		.indirect_pointer_one(p1), .mv_wdata(mwv), .mv_rdata_q(mrd),
		.mv_done_q(dn), .mv_busy_q(bz), .ext_addr_hi_q(ah),
		.ext_addr_hi_oe_q(hoe), .ext_addr_lo_q(al), .ext_addr_lo_oe_q(loe),
		.ext_data_i(di), .ext_data_o_q(dout), .ext_data_oe_q(doe),
		.ext_rd_n_q(rdn), .ext_wr_n_q(wrn), .ext_ale_q(ale));
	emi_xmem xm (.clk(clk), .ext_addr_hi_q(ah), .ext_addr_hi_oe_q(hoe),
		.ext_addr_lo_q(al), .ext_addr_lo_oe_q(loe), .ext_data_i(di),
		.ext_data_o_q(dout), .ext_rd_n_q(rdn), .ext_wr_n_q(wrn),
		.ext_ale_q(ale));
	// compare one result
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// counts and verdict
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// one avalon-mm access, held until waitrequest is low
	task automatic rw(input logic w, input logic [7:0] x, input logic [7:0] d);
		int k;
		@(posedge clk);
		adr <= {x, 2'b00};
		rd <= ~w;
		wr <= w;
		wdat <= {24'h0, d};
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (wq !== 1'b0 && k < 50);
		r = rdat[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
		if (k == 50) begin
			n_errors++;
			stop_test;
		end
	endtask
	// one move; n is the cycle of done counted from the accept edge
	task automatic mv(input logic w, wd, sl, input logic [15:0] a,
		input logic [7:0] p, input logic [7:0] v);
		@(posedge clk);
		req <= 1'b1;
		mw <= w;
		mwd <= wd;
		msel <= sl;
		dp <= a;
		p0 <= sl ? ~p : p;
		p1 <= sl ? p : ~p;
		mwv <= v;
		@(posedge clk);
		req <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (dn !== 1'b1 && n < 60);
		r = mrd;
		if (n == 60) begin
			n_errors++;
			stop_test;
		end
	endtask
	// clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// main sequence
	initial begin
		{rstn, rd, wr, req, mw, mwd, msel} = 7'h00;
		{adr, wdat, dp, p0, p1, mwv} = 0;
		be = 4'h1;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		rw(0, `EMI_TIMING_IDX, 0);
		chk(r, 8'hff);
		rw(0, 8'h20, 0);
		chk(r, 8'h00);
		// write without byte lane zero must be ignored
		be <= 4'h0;
		rw(1, `EMI_PAGE_IDX, 8'h77);
		be <= 4'h1;
		rw(0, `EMI_PAGE_IDX, 0);
		chk(r, `EMI_PAGE_RST);
		$display("test registers done");
		rw(1, `EMI_CONFIG_IDX, 8'h1c);
		for (i = 0; i < 3; i++) begin
			rw(1, `EMI_TIMING_IDX, tv[i]);
			mv(1, 1, 0, 16'(18 + i), 0, 8'(48 + i));
			chk(n, ne[i]);
			chk(xm.mem[18 + i], 8'(48 + i));
			chk(xm.l_hioe, 1);
		end
		rw(1, `EMI_TIMING_IDX, 8'h0c);
		rw(0, `EMI_TIMING_IDX, 0);
		chk(r, 8'h0c);
		rw(1, `EMI_PAGE_IDX, 8'h55);
		mv(0, 0, 1, 0, 8'h12, 0);
		chk(r, 8'h30);
		chk(xm.l_hioe, 0);
		rw(1, `EMI_CONFIG_IDX, 8'h0f);
		mv(0, 1, 0, 16'h0013, 0, 0);
		chk({r, 8'(n)}, {8'h31, 8'd16});
		rw(0, `EMI_STATUS_IDX, 0);
		chk(r, 8'h06);
		$display("test external only done");
		rw(1, `EMI_CONFIG_IDX, 8'h10);
		rw(1, `EMI_PAGE_IDX, 8'h00);
		s = xm.n_strb;
		mv(1, 1, 0, 16'h1034, 0, 8'ha5);
		chk(n, 3);
		mv(0, 1, 0, 16'h2034, 0, 0);
		chk(r, 8'ha5);
		mv(0, 0, 0, 0, 8'h34, 0);
		chk(r, 8'ha5);
		chk(xm.n_strb - s, 0);
		$display("test internal only done");
		rw(1, `EMI_CONFIG_IDX, 8'h14);
		mv(0, 1, 0, 16'h0034, 0, 0);
		chk({r, 8'(n)}, {8'ha5, 8'd3});
		mv(1, 1, 0, 16'h1000, 0, 8'h77);
		chk({xm.l_addr, 8'(n)}, {16'h1000, 8'd8});
		rw(1, `EMI_PAGE_IDX, 8'h10);
		mv(1, 0, 1, 0, 8'h12, 8'h66);
		chk({xm.l_hioe, xm.l_addr}, {1'b0, 16'h0012});
		rw(1, `EMI_CONFIG_IDX, 8'h18);
		mv(1, 0, 1, 0, 8'h12, 8'h66);
		chk({xm.l_hioe, xm.l_addr}, {1'b1, 16'h1012});
		chk(xm.mem[16'h1012], 8'h66);
		$display("test split modes done");
		stop_test;
	end
endmodule // testbench
bind emi_ext_data_mem emi_chk u_chk (.clk(clk), .rstn(rstn),
	.mv_busy_q(mv_busy_q), .mv_done_q(mv_done_q),
	.ext_addr_hi_oe_q(ext_addr_hi_oe_q), .ext_addr_lo_q(ext_addr_lo_q),
	.ext_data_oe_q(ext_data_oe_q), .ext_rd_n_q(ext_rd_n_q),
	.ext_wr_n_q(ext_wr_n_q), .ext_ale_q(ext_ale_q));
`default_nettype wire

//--- verilog/emi_defines.vh
// constants of the external data memory interface: register indices,
// field positions, reset values, modes and access timing counts.
// assumes inclusion by the design top and by the bench top.
`ifndef EMI_DEFINES_VH
`define EMI_DEFINES_VH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define EMI_PAGE_IDX      8'ha8
`define EMI_CONFIG_IDX    8'ha9
`define EMI_TIMING_IDX    8'haa
`define EMI_STATUS_IDX    8'hab

// ****************************************************************
// reset values
// ****************************************************************
`define EMI_PAGE_RST      8'h00
`define EMI_CONFIG_RST    8'h00
`define EMI_TIMING_RST    8'hff

// ****************************************************************
// field positions
// ****************************************************************
`define EMI_TIM_SETUP_HI  7
`define EMI_TIM_SETUP_LO  6
`define EMI_TIM_STRB_HI   5
`define EMI_TIM_STRB_LO   2
`define EMI_TIM_HOLD_HI   1
`define EMI_TIM_HOLD_LO   0
`define EMI_CFG_LATCH_HI  1
`define EMI_CFG_LATCH_LO  0
`define EMI_CFG_MODE_HI   3
`define EMI_CFG_MODE_LO   2
`define EMI_CFG_MUXSEL    4

// ****************************************************************
// memory modes and address boundary
// ****************************************************************
`define EMI_MODE_INT      2'h0
`define EMI_MODE_SPLIT    2'h1
`define EMI_MODE_BANK     2'h2
`define EMI_MODE_EXT      2'h3
`define EMI_RAM_BOUND     16'h1000

// ****************************************************************
// timing counts in system clock cycles
// ****************************************************************
`define EMI_EXTRA_CYC     4
`define EMI_TAIL_LAST     4'h1

`endif

//--- verilog/emi_ext_data_mem.v
// external data memory interface: steers move accesses to internal ram
// or to an off-chip parallel bus with programmable timing.
// assumes an avalon-mm master on clk and a core issuing one move at a time.
//
// Contract
// - mode 00 sends every move to internal ram, no bus cycle.
// - internal-only mode aliases addresses modulo 4 kB.
// - internal-only 8-bit move: high byte from page, low from pointer.
// - internal-only 16-bit move uses the full data pointer.
// - modes 01/10: below ram size internal, above it off-chip.
// - mode 01 8-bit off-chip leaves A[15:8] undriven; page decides target.
// - mode 01 8-bit off-chip drives A[7:0] from selected pointer.
// - split 16-bit move decides by data pointer, drives A[15:0].
// - mode 10 8-bit off-chip drives A[15:8] page, A[7:0] pointer.
// - mode 11 sends every move off-chip; internal ram invisible.
// - mode 11 8-bit ignores page, A[15:8] undriven, A[7:0] pointer.
// - mode 11 16-bit drives A[15:0] from data pointer.
// - setup, hold, strobe and latch widths programmable in clock cycles.
// - off-chip move lasts setup plus strobe plus hold plus 4 cycles.
// - multiplexed access adds at least 2 cycles of latch pulse.
// - timing register resets to all ones, maximum setup and hold.
// - strobe width is field code plus one cycles, 1 to 16.
// - write data hold equals its field code in cycles, 0 to 3; address stays two cycles more.
// - latch high and low each last latch code plus one cycles.
// - low address on shared bus while latch high; latched on fall.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "emi_defines.vh"

module emi_ext_data_mem #(
	parameter RAM_AW = 12
) (
	// clock and reset
	input  wire        clk,
	input  wire        rstn,
	// avalon-mm register slave
	input  wire [9:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	// core move port
	input  wire        mv_req,
	input  wire        mv_write,
	input  wire        mv_wide,
	input  wire        mv_ptr_sel,
	input  wire [15:0] data_pointer,
	input  wire [7:0]  indirect_pointer_zero,
	input  wire [7:0]  indirect_pointer_one,
	input  wire [7:0]  mv_wdata,
	output reg  [7:0]  mv_rdata_q,
	output reg         mv_done_q,
	output reg         mv_busy_q,
	// external bus pins
	output reg  [7:0]  ext_addr_hi_q,
	output reg         ext_addr_hi_oe_q,
	output reg  [7:0]  ext_addr_lo_q,
	output reg         ext_addr_lo_oe_q,
	input  wire [7:0]  ext_data_i,
	output reg  [7:0]  ext_data_o_q,
	output reg         ext_data_oe_q,
	output reg         ext_rd_n_q,
	output reg         ext_wr_n_q,
	output reg         ext_ale_q
);

	// one-hot states
	localparam [10:0] S_IDLE  = 11'h001;
	localparam [10:0] S_RAM   = 11'h002;
	localparam [10:0] S_RAMW  = 11'h004;
	localparam [10:0] S_START = 11'h008;
	localparam [10:0] S_ALEH  = 11'h010;
	localparam [10:0] S_ALEL  = 11'h020;
	localparam [10:0] S_SETUP = 11'h040;
	localparam [10:0] S_STRB  = 11'h080;
	localparam [10:0] S_HOLD  = 11'h100;
	localparam [10:0] S_TAIL  = 11'h200;
	localparam [10:0] S_DONE  = 11'h400;

	reg  [7:0]  page_q;
	reg  [7:0]  config_q;
	reg  [7:0]  timing_q;
	reg  [10:0] st_q;
	reg  [10:0] st_d;
	reg  [3:0]  cnt_q;
	reg  [3:0]  cnt_d;
	reg  [15:0] ea_q;
	reg         hi_q;
	reg         mux_q;
	reg         write_q;
	reg  [7:0]  wdata_q;
	reg  [7:0]  tim_q;
	reg  [1:0]  latw_q;
	reg         ram_en_q;
	reg         ram_we_q;
	reg  [RAM_AW-1:0] ram_addr_q;
	reg  [7:0]  din_s1_q;
	reg  [7:0]  din_s2_q;
	reg         last_ext_q;
	wire [7:0]  ram_rdata;

	// ****************************************************************
	// address decode
	// ****************************************************************

	// target decision for an effective address under a mode
	function is_internal;
		input [1:0]  mode;
		input [15:0] ea;
		begin
			case (mode)
				`EMI_MODE_INT:   is_internal = 1'b1;
				`EMI_MODE_EXT:   is_internal = 1'b0;
				default:         is_internal = (ea < `EMI_RAM_BOUND);
			endcase
		end
	endfunction

	wire [1:0]  mode_c = config_q[`EMI_CFG_MODE_HI:`EMI_CFG_MODE_LO];
	wire [7:0]  ptr_c  = mv_ptr_sel ? indirect_pointer_one
	                                : indirect_pointer_zero;
	// page and pointer form the short address
	// wide move takes the data pointer whole
	wire [15:0] ea_c   = mv_wide ? data_pointer : {page_q, ptr_c};
	wire        int_c  = is_internal(mode_c, ea_c);
	// short move in mode 01 leaves high lines alone
	// short move in mode 11 leaves high lines alone
	// bank select drives the high lines
	wire        hi_c   = mv_wide || (mode_c == `EMI_MODE_BANK);
	wire        mux_c  = ~config_q[`EMI_CFG_MUXSEL];
	wire        acc    = mv_req && st_q[0];

	// context as seen by the next state
	wire [15:0] ea_n   = acc ? ea_c : ea_q;
	wire        hi_n   = acc ? hi_c : hi_q;
	wire        mux_n  = acc ? mux_c : mux_q;
	wire        wr_n   = acc ? mv_write : write_q;
	wire [7:0]  wd_n   = acc ? mv_wdata : wdata_q;

	wire [1:0]  f_setup = tim_q[`EMI_TIM_SETUP_HI:`EMI_TIM_SETUP_LO];
	wire [3:0]  f_strb  = tim_q[`EMI_TIM_STRB_HI:`EMI_TIM_STRB_LO];
	wire [1:0]  f_hold  = tim_q[`EMI_TIM_HOLD_HI:`EMI_TIM_HOLD_LO];

	// ****************************************************************
	// access sequencer
	// ****************************************************************

	// next state and phase counter
	always @* begin
		st_d  = st_q;
		cnt_d = cnt_q + 4'h1;
		case (st_q)
			S_IDLE: begin
				cnt_d = 4'h0;
				if (acc) begin
					// internal moves bypass the bus sequence
					st_d = int_c ? S_RAM : S_START;
				end
			end
			S_RAM:  st_d = S_RAMW;
			S_RAMW: st_d = S_DONE;
			S_START: begin
				cnt_d = 4'h0;
				if (mux_q)
					st_d = S_ALEH;
				else if (f_setup != 2'h0)
					st_d = S_SETUP;
				else
					st_d = S_STRB;
			end
			S_ALEH: begin
				// latch high for code plus one cycles
				if (cnt_q == {2'h0, latw_q}) begin
					st_d  = S_ALEL;
					cnt_d = 4'h0;
				end
			end
			S_ALEL: begin
				// latch low for code plus one cycles
				if (cnt_q == {2'h0, latw_q}) begin
					cnt_d = 4'h0;
					st_d  = (f_setup != 2'h0) ? S_SETUP : S_STRB;
				end
			end
			S_SETUP: begin
				if (cnt_q == {2'h0, f_setup} - 4'h1) begin
					st_d  = S_STRB;
					cnt_d = 4'h0;
				end
			end
			S_STRB: begin
				// strobe for code plus one cycles
				if (cnt_q == f_strb) begin
					cnt_d = 4'h0;
					st_d  = (f_hold != 2'h0) ? S_HOLD : S_TAIL;
				end
			end
			S_HOLD: begin
				if (cnt_q == {2'h0, f_hold} - 4'h1) begin
					st_d  = S_TAIL;
					cnt_d = 4'h0;
				end
			end
			S_TAIL: begin
				// start, two tail cycles and done add four
				if (cnt_q == `EMI_TAIL_LAST)
					st_d = S_DONE;
			end
			S_DONE: st_d = S_IDLE;
			default: st_d = S_IDLE;
		endcase
	end

	// state, context latch and completion
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q       <= S_IDLE;
			cnt_q      <= 4'h0;
			ea_q       <= 16'h0000;
			hi_q       <= 1'b0;
			mux_q      <= 1'b0;
			write_q    <= 1'b0;
			wdata_q    <= 8'h00;
			tim_q      <= `EMI_TIMING_RST;
			latw_q     <= 2'h0;
			ram_en_q   <= 1'b0;
			ram_we_q   <= 1'b0;
			ram_addr_q <= {RAM_AW{1'b0}};
			mv_rdata_q <= 8'h00;
			mv_done_q  <= 1'b0;
			mv_busy_q  <= 1'b0;
			last_ext_q <= 1'b0;
		end else begin
			st_q      <= st_d;
			cnt_q     <= cnt_d;
			mv_done_q <= (st_d == S_DONE);
			mv_busy_q <= (st_d != S_IDLE);
			ram_en_q  <= acc && int_c;
			if (acc) begin
				ea_q       <= ea_c;
				hi_q       <= hi_c;
				mux_q      <= mux_c;
				write_q    <= mv_write;
				wdata_q    <= mv_wdata;
				tim_q      <= timing_q;
				latw_q     <= config_q[`EMI_CFG_LATCH_HI:`EMI_CFG_LATCH_LO];
				ram_we_q   <= mv_write;
				// aliasing by dropping upper address bits
				ram_addr_q <= ea_c[RAM_AW-1:0];
				last_ext_q <= ~int_c;
			end
			// read data from ram or from the synchronised bus
			if (st_q == S_RAMW && !write_q)
				mv_rdata_q <= ram_rdata;
			if (st_q == S_STRB && st_d != S_STRB && !write_q)
				mv_rdata_q <= din_s2_q;
		end
	end

	// ****************************************************************
	// external pins
	// ****************************************************************

	wire ext_d  = (st_d == S_START) || (st_d == S_ALEH) ||
	              (st_d == S_ALEL)  || (st_d == S_SETUP) ||
	              (st_d == S_STRB)  || (st_d == S_HOLD) ||
	              (st_d == S_TAIL);
	wire wdat_d = (st_d == S_SETUP) || (st_d == S_STRB) ||
	              (st_d == S_HOLD);
	wire adat_d = mux_n && ((st_d == S_START) || (st_d == S_ALEH));

	// pin registers follow the next state
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ext_addr_hi_q    <= 8'h00;
			ext_addr_hi_oe_q <= 1'b0;
			ext_addr_lo_q    <= 8'h00;
			ext_addr_lo_oe_q <= 1'b0;
			ext_data_o_q     <= 8'h00;
			ext_data_oe_q    <= 1'b0;
			ext_rd_n_q       <= 1'b1;
			ext_wr_n_q       <= 1'b1;
			ext_ale_q        <= 1'b0;
			din_s1_q         <= 8'h00;
			din_s2_q         <= 8'h00;
		end else begin
			din_s1_q <= ext_data_i;
			din_s2_q <= din_s1_q;
			// wide moves drive all sixteen lines, the low eight via the data bus when multiplexed
			// wide moves in mode 11 as well
			ext_addr_hi_oe_q <= ext_d && hi_n;
			ext_addr_hi_q    <= ea_n[15:8];
			// low lines from the selected pointer, from the data pointer on wide moves
			ext_addr_lo_oe_q <= ext_d && !mux_n;
			ext_addr_lo_q    <= ea_n[7:0];
			// low address on shared bus while latch high
			ext_ale_q        <= (st_d == S_ALEH);
			ext_data_oe_q    <= adat_d || (ext_d && wdat_d && wr_n);
			ext_data_o_q     <= adat_d ? ea_n[7:0] : wd_n;
			ext_rd_n_q       <= ~((st_d == S_STRB) && !wr_n);
			ext_wr_n_q       <= ~((st_d == S_STRB) && wr_n);
		end
	end

	// ****************************************************************
	// internal ram
	// ****************************************************************

	emi_ram #(
		.AW (RAM_AW),
		.DW (8)
	) u_ram (
		.clk     (clk),
		.rstn    (rstn),
		.en      (ram_en_q),
		.we      (ram_we_q),
		.addr    (ram_addr_q),
		.wdata   (wdata_q),
		.rdata_q (ram_rdata)
	);

	// ****************************************************************
	// register slave
	// ****************************************************************

	wire [7:0] reg_idx = avs_address[9:2];
	wire       bus_req = (avs_read || avs_write) && avs_waitrequest;
	wire [7:0] status  = {5'h00, mux_q, last_ext_q, mv_busy_q};

	// one wait cycle, then a single-cycle answer
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
			page_q          <= `EMI_PAGE_RST;
			config_q        <= `EMI_CONFIG_RST;
			timing_q        <= `EMI_TIMING_RST;
		end else begin
			avs_waitrequest <= ~bus_req;
			if (bus_req && avs_read) begin
				case (reg_idx)
					`EMI_PAGE_IDX:   avs_readdata <= {24'h0, page_q};
					`EMI_CONFIG_IDX: avs_readdata <= {24'h0, config_q};
					`EMI_TIMING_IDX: avs_readdata <= {24'h0, timing_q};
					`EMI_STATUS_IDX: avs_readdata <= {24'h0, status};
					default:         avs_readdata <= 32'h0000_0000;
				endcase
			end
			// a write lands only at the edge that completes the transfer
			if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
				case (reg_idx)
					`EMI_PAGE_IDX:   page_q   <= avs_writedata[7:0];
					`EMI_CONFIG_IDX: config_q <= avs_writedata[7:0];
					`EMI_TIMING_IDX: timing_q <= avs_writedata[7:0];
					default:         ;
				endcase
			end
		end
	end

endmodule // emi_ext_data_mem

`default_nettype wire

//--- verilog/emi_ram.v
// internal data ram of the external data memory interface.
// assumes one clock; read data appear one edge after the enable.
`timescale 1ns/1ns
`default_nettype none

module emi_ram #(
	parameter AW = 12,
	parameter DW = 8
) (
	// clock and reset
	input  wire          clk,
	input  wire          rstn,
	// access port
	input  wire          en,
	input  wire          we,
	input  wire [AW-1:0] addr,
	input  wire [DW-1:0] wdata,
	output reg  [DW-1:0] rdata_q
);

	reg [DW-1:0] mem [0:(1<<AW)-1];

	// storage array, no reset
	always @(posedge clk) begin
		if (en && we) begin
			mem[addr] <= wdata;
		end
	end

	// registered read port
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= {DW{1'b0}};
		end else if (en && !we) begin
			rdata_q <= mem[addr];
		end
	end

endmodule // emi_ram

`default_nettype wire
